// file: hdl/mps_mdio.sv
module mps_mdio (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised management line
  input wire logic mdc_rise,
  input wire logic mdio_in,
  // Own address and register read data
  input wire logic [4:0] phy_addr,
  input wire logic [15:0] rd_data,
  // Register request towards the core
  output mps_pkg::mps_req_s req,
  // Line drive
  output logic mdio_o,
  output logic mdio_oe
);
  import mps_pkg::*;

  typedef enum logic [2:0] {
    ST_PRE, ST_HDR, ST_TA, ST_TA0, ST_RD, ST_WTA, ST_WR
  } mps_mdio_e;

  mps_mdio_e state, next_state;
  logic [5:0] ones, next_ones;
  logic [4:0] cnt, next_cnt;
  logic [15:0] sh, next_sh;
  logic next_oe, next_dout;
  mps_req_s next_req;

  // Frame walker, advanced only on management clock rising edges
  always_comb begin
    next_state = state;
    next_ones = ones;
    next_cnt = cnt;
    next_sh = sh;
    next_oe = mdio_oe;
    next_dout = mdio_o;
    next_req = req;
    next_req.rd = 1'b0;
    next_req.wr = 1'b0;
    if (req.rd) begin
      next_sh = rd_data; // Read data settle during turnaround
    end
    if (mdc_rise) begin
      unique case (state)
        ST_PRE: begin
          if (mdio_in) begin
            next_ones = (ones == PRE_ONES) ? ones : ones + 6'h01;
          end else if (ones == PRE_ONES) begin
            next_state = ST_HDR;
            next_cnt = 5'h00;
            next_ones = 6'h00;
          end else begin
            next_ones = 6'h00;
          end
        end
        ST_HDR: begin
          next_sh = {sh[14:0], mdio_in};
          next_cnt = cnt + 5'h01;
          // Start bit's leading zero ended the preamble; 13 bits remain
          if (cnt == HDR_LAST) begin
            next_state = ST_PRE;
            next_cnt = 5'h00;
            next_req.addr = next_sh[4:0];
            if (next_sh[12] && next_sh[9:5] == phy_addr) begin
              if (next_sh[11:10] == OP_RD) begin
                next_state = ST_TA;
                next_req.rd = 1'b1;
              end else if (next_sh[11:10] == OP_WR) begin
                next_state = ST_WTA;
              end
            end
          end
        end
        ST_TA: begin
          next_state = ST_TA0;
          next_oe = 1'b1;
          next_dout = 1'b0;
        end
        ST_TA0: begin
          next_state = ST_RD;
          next_dout = sh[15];
          next_sh = {sh[14:0], 1'b0};
          next_cnt = 5'h00;
        end
        ST_RD: begin
          if (cnt == DATA_LAST) begin
            next_state = ST_PRE;
            next_oe = 1'b0;
          end else begin
            next_dout = sh[15];
            next_sh = {sh[14:0], 1'b0};
            next_cnt = cnt + 5'h01;
          end
        end
        ST_WTA: begin
          next_cnt = cnt + 5'h01;
          if (cnt == 5'h01) begin
            next_state = ST_WR;
            next_cnt = 5'h00;
          end
        end
        ST_WR: begin
          next_sh = {sh[14:0], mdio_in};
          next_cnt = cnt + 5'h01;
          if (cnt == DATA_LAST) begin
            next_state = ST_PRE;
            next_req.wr = 1'b1;
            next_req.data = next_sh;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_PRE;
      ones <= 6'h00;
      cnt <= 5'h00;
      sh <= 16'h0000;
      mdio_oe <= 1'b0;
      mdio_o <= 1'b0;
      req <= '0;
    end else begin
      state <= next_state;
      ones <= next_ones;
      cnt <= next_cnt;
      sh <= next_sh;
      mdio_oe <= next_oe;
      mdio_o <= next_dout;
      req <= next_req;
    end
  end

  a_mdio_ta_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_TA0) |-> (mdio_oe && !mdio_o))
    else $error("turnaround bit not driven low");
endmodule

// file: hdl/mps_pkg.sv
package mps_pkg;
  // Clock and receive clock rates
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RXCLK_100_HZ = 25_000_000;
  localparam int unsigned RXCLK_NIB_HZ = 2_500_000;
  localparam int unsigned RXCLK_SER_HZ = 10_000_000;
  // Upper management clock rate, kept by the controller
  localparam int unsigned MDC_MAX_HZ = 16_670_000;
  // Half-period counts of the receive clock, minus one
  localparam logic [6:0] HALF_100 = 7'(CLK_HZ / (2 * RXCLK_100_HZ) - 1);
  localparam logic [6:0] HALF_NIB = 7'(CLK_HZ / (2 * RXCLK_NIB_HZ) - 1);
  localparam logic [6:0] HALF_SER = 7'(CLK_HZ / (2 * RXCLK_SER_HZ) - 1);
  // Register addresses
  localparam logic [4:0] ADDR_ISR = 5'h11;
  localparam logic [4:0] ADDR_MASK = 5'h12;
  localparam logic [4:0] ADDR_SELF = 5'h19;
  localparam logic [15:0] MASK_RST = 16'h0000;
  // Self status layout: address in [4:0], drive strap above it
  localparam int SELF_DRV_BIT = 5;
  // Management frame constants
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [1:0] OP_RD = 2'b10;
  localparam logic [1:0] OP_WR = 2'b01;
  localparam logic [4:0] HDR_LAST = 5'h0c;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  // Positions in the synchronised pin vector
  localparam int I_RXEN = 0;
  localparam int I_MDC = 1;
  localparam int I_MDIO = 2;
  localparam int I_COL = 3;
  localparam int I_CRS = 4;
  localparam int I_DV = 5;
  localparam int I_ER = 6;
  localparam int I_RXD3 = 7;
  localparam int I_RXD1 = 8;
  localparam int I_HUB = 9;
  localparam int I_SER = 10;
  localparam int N_SYNC = 11;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } mps_rx_s;

  typedef struct packed {
    logic [4:0] phy_addr;
    logic drive;
    logic hub;
    logic serial;
  } mps_strap_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] data;
  } mps_req_s;
endpackage

// file: hdl/mps_rxclk.sv
module mps_rxclk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Rate select
  input wire logic speed_100,
  input wire logic serial,
  // Free-running receive clock
  output logic rx_clk
);
  import mps_pkg::*;

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [6:0] half;
  logic next_rx_clk;

  // Toggle every half period; >= lets a rate change settle at once
  always_comb begin
    half = speed_100 ? HALF_100 : (serial ? HALF_SER : HALF_NIB);
    next_cnt = cnt + 7'h01;
    next_rx_clk = rx_clk;
    if (cnt >= half) begin
      next_cnt = 7'h00;
      next_rx_clk = ~rx_clk;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 7'h00;
      rx_clk <= 1'b0;
    end else begin
      cnt <= next_cnt;
      rx_clk <= next_rx_clk;
    end
  end

  a_rxclk_half: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt > half) |=> (cnt == 7'h00))
    else $error("receive clock counter overran its half period");
endmodule

// file: hdl/mps_status_pins.sv
module mps_status_pins (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // State from the transceiver core
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic sqe,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire mps_pkg::mps_rx_s rx_in,
  input wire logic [15:0] evt_state,
  // Strap-only pins and receive enable
  input wire logic repeater_i,
  input wire logic serial_i,
  input wire logic rx_en_i,
  // Collision and carrier sense pins
  input wire logic col_i,
  output logic col_o,
  output logic col_oe,
  input wire logic crs_i,
  output logic crs_o,
  output logic crs_oe,
  // Receive pins
  input wire logic [3:0] rxd_i,
  output logic [3:0] rxd_o,
  output logic rxd_oe,
  input wire logic rx_dv_i,
  output logic rx_dv_o,
  output logic rx_dv_oe,
  input wire logic rx_er_i,
  output logic rx_er_o,
  output logic rx_er_oe,
  output logic rx_clk_o,
  output logic rx_clk_oe,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  output logic irq_pin_o,
  output logic irq_pin_oe,
  // Local register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  // Latched strap results
  output logic drive_strength_strap,
  output logic ten_meg_serial_select
);
  import mps_pkg::*;

  logic [N_SYNC-1:0] pin_raw, sync_a, sync_b;
  logic mdc_d, mdc_rise;
  mps_strap_s strap, next_strap;
  logic drv_en, next_drv_en;
  mps_rx_s rx_q, next_rx_q;
  logic next_col, next_crs;
  logic [15:0] interrupt_status_register, next_isr, mask, next_mask, evt_prev, change;
  logic [15:0] next_rdata, self_word, mdio_rdata;
  logic rd_isr;
  mps_req_s mreq;
  logic rx_en_s;

  // Register read decode, shared by the local port and management frames
  function automatic logic [15:0] reg_read(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      ADDR_ISR: v = interrupt_status_register;
      ADDR_MASK: v = mask;
      ADDR_SELF: v = self_word;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Pins from outside pass two flops before anything reads them
  assign pin_raw = {serial_i, repeater_i, rxd_i[1], rxd_i[3], rx_er_i,
                    rx_dv_i, crs_i, col_i, mdio_i, mdc, rx_en_i};

  always_ff @(posedge clk) begin
    sync_a <= pin_raw;
    sync_b <= sync_a;
    mdc_d <= sync_b[I_MDC];
  end

  // Edge found in the system clock domain; no logic on the raw clock
  assign mdc_rise = sync_b[I_MDC] & ~mdc_d;
  assign rx_en_s = sync_b[I_RXEN];

  // Straps track the pins while reset is low and freeze at release
  always_comb begin
    next_strap = strap;
    next_drv_en = 1'b1;
    if (!rst_n) begin
      next_strap.phy_addr[0] = sync_b[I_COL];
      next_strap.phy_addr[1] = sync_b[I_RXD1];
      next_strap.phy_addr[2] = sync_b[I_CRS];
      next_strap.phy_addr[3] = sync_b[I_RXD3];
      next_strap.phy_addr[4] = sync_b[I_ER];
      next_strap.drive = sync_b[I_DV];
      next_strap.hub = sync_b[I_HUB];
      next_strap.serial = sync_b[I_SER];
      next_drv_en = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    strap <= next_strap;
    drv_en <= next_drv_en;
  end

  assign drive_strength_strap = strap.drive;
  assign ten_meg_serial_select = strap.serial;
  // Drive strap sits directly above the five address bits
  assign self_word = {10'h000, strap.drive, strap.phy_addr};

  // Collision and carrier sense; COL is held low in full duplex
  always_comb begin
    next_col = !full_duplex && (collision || (!speed_100 && sqe));
    if (strap.hub || full_duplex) begin
      next_crs = rx_active;
    end else begin
      next_crs = rx_active || tx_active;
    end
    next_rx_q = rx_in;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      col_o <= 1'b0;
      crs_o <= 1'b0;
      rx_q <= '0;
    end else begin
      col_o <= next_col;
      crs_o <= next_crs;
      rx_q <= next_rx_q;
    end
  end

  // Shared pins turn to outputs only after straps are frozen
  assign col_oe = drv_en;
  assign crs_oe = drv_en;
  assign rxd_o = rx_q.d;
  assign rx_dv_o = rx_q.dv;
  assign rx_er_o = rx_q.er;
  // Release lets several transceivers share one receive bus
  assign rxd_oe = drv_en && rx_en_s;
  assign rx_dv_oe = drv_en && rx_en_s;
  assign rx_er_oe = drv_en && rx_en_s;
  assign rx_clk_oe = drv_en && rx_en_s;

  mps_rxclk u_rxclk (
    .clk(clk),
    .rst_n(rst_n),
    .speed_100(speed_100),
    .serial(strap.serial),
    .rx_clk(rx_clk_o)
  );

  assign mdio_rdata = reg_read(mreq.addr);

  mps_mdio u_mdio (
    .clk(clk),
    .rst_n(rst_n),
    .mdc_rise(mdc_rise),
    .mdio_in(sync_b[I_MDIO]),
    .phy_addr(strap.phy_addr),
    .rd_data(mdio_rdata),
    .req(mreq),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe)
  );

  // Status: changes set, reads clear all, writes of one clear; set wins
  always_comb begin
    change = evt_state ^ evt_prev;
    rd_isr = (reg_rd && reg_addr == ADDR_ISR) ||
             (mreq.rd && mreq.addr == ADDR_ISR);
    next_isr = interrupt_status_register;
    next_mask = mask;
    if (rd_isr) begin
      next_isr = 16'h0000;
    end
    if (reg_wr && reg_addr == ADDR_ISR) begin
      next_isr = next_isr & ~reg_wdata;
    end
    if (mreq.wr && mreq.addr == ADDR_ISR) begin
      next_isr = next_isr & ~mreq.data;
    end
    if (reg_wr && reg_addr == ADDR_MASK) begin
      next_mask = reg_wdata;
    end else if (mreq.wr && mreq.addr == ADDR_MASK) begin
      next_mask = mreq.data;
    end
    next_isr = next_isr | change;
    next_rdata = reg_rd ? reg_read(reg_addr) : 16'h0000;
  end

  always_ff @(posedge clk) begin
    evt_prev <= evt_state;
    if (!rst_n) begin
      interrupt_status_register <= 16'h0000;
      mask <= MASK_RST;
      reg_rdata <= 16'h0000;
    end else begin
      interrupt_status_register <= next_isr;
      mask <= next_mask;
      reg_rdata <= next_rdata;
    end
  end

  // Open-drain pin: only ever drives low
  assign irq = |(interrupt_status_register & mask);
  assign irq_pin_o = 1'b0;
  assign irq_pin_oe = irq;

  a_col_fdx_low: assert property (@(posedge clk) disable iff (!rst_n)
    full_duplex |=> !col_o)
    else $error("COL high in full duplex");

  a_col_collision: assert property (@(posedge clk) disable iff (!rst_n)
    (!full_duplex && collision) |=> col_o)
    else $error("collision not shown on COL");

  a_col_sqe_slow: assert property (@(posedge clk) disable iff (!rst_n)
    (!full_duplex && !speed_100 && sqe) |=> col_o)
    else $error("signal quality error not shown at low speed");

  a_crs_rx_only: assert property (@(posedge clk) disable iff (!rst_n)
    ((strap.hub || full_duplex) && !rx_active) |=> !crs_o)
    else $error("CRS shows transmit in receive-only mode");

  a_crs_tx_half: assert property (@(posedge clk) disable iff (!rst_n)
    (!strap.hub && !full_duplex && tx_active) |=> crs_o)
    else $error("CRS misses transmit in half duplex");

  a_strap_capture: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(drv_en) |-> (strap.phy_addr[0] == $past(sync_b[I_COL], 2)) &&
      (strap.phy_addr[2] == $past(sync_b[I_CRS], 2)) &&
      (strap.phy_addr[4] == $past(sync_b[I_ER], 2)) &&
      (strap.phy_addr[1] == $past(sync_b[I_RXD1], 2)) &&
      (strap.drive == $past(sync_b[I_DV], 2)))
    else $error("strap not taken from the last reset cycle");

  a_strap_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    drv_en |=> $stable(strap))
    else $error("strap changed after reset release");

  a_rx_dv_follow: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> (rx_dv_o == $past(rx_in.dv)) &&
      (rxd_o == $past(rx_in.d)))
    else $error("RX_DV out of step with data");

  a_rx_release: assert property (@(posedge clk) disable iff (!rst_n)
    !rx_en_s |-> !rxd_oe && !rx_dv_oe && !rx_clk_oe)
    else $error("receive pins driven while disabled");

  a_irq_on_change: assert property (@(posedge clk) disable iff (!rst_n)
    (|(change & next_mask)) |=> irq_pin_oe)
    else $error("unmasked change did not assert interrupt");

  a_isr_read_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_isr && change == 16'h0000) |=> (interrupt_status_register == 16'h0000) && !irq)
    else $error("status read did not clear interrupt");

  a_mdc_edge: assert property (@(posedge clk) disable iff (!rst_n)
    mdc_rise |=> !mdc_rise)
    else $error("management clock edge longer than one cycle");
endmodule

// file: verification/mps_mac_model.sv
// Media access controller side of the management link
module mps_mac_model (
  // Management pins towards the device
  output logic mdc,
  output logic mdio_val,
  output logic mdio_en,
  input wire logic mdio_line
);
  timeunit 1ns;
  timeprecision 100ps;
  import mps_pkg::*;
  // 125 ns period keeps the clock under its upper rate
  localparam realtime HALF = 62.5;
  initial begin
    mdc = 1'b0;
    mdio_val = 1'b1;
    mdio_en = 1'b0;
  end
  // Data set while the clock is low, line sampled at the rise
  task automatic bit_cyc(input logic d, output logic s);
    mdio_val = d;
    #HALF;
    mdc = 1'b1;
    s = mdio_line;
    #HALF;
    mdc = 1'b0;
  endtask
  // Clock stands low between frames; every frame has its own preamble
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, phy, rg};
    mdio_en = 1'b1;
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], s);
    if (op == OP_WR) begin
      bit_cyc(1'b1, s);
      bit_cyc(1'b0, s);
      for (int i = 15; i >= 0; i--) bit_cyc(wd[i], s);
      rd = wd;
    end else begin
      // Line handed over at turnaround; device answers on it
      mdio_en = 1'b0;
      bit_cyc(1'b1, s);
      bit_cyc(1'b1, s);
      for (int i = 15; i >= 0; i--) begin
        bit_cyc(1'b1, s);
        rd[i] = s;
      end
    end
    mdio_en = 1'b0;
  endtask
endmodule

// file: verification/mps_status_pins_tb.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module mps_status_pins_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mps_pkg::*;
  logic clk, rst_n, speed_100, full_duplex, collision, sqe;
  logic rx_active, tx_active, repeater_i, serial_i, rx_en_i;
  logic col_s, crs_s, dv_s, er_s, reg_wr, reg_rd, mdc, mac_val, mac_en;
  logic [3:0] rxd_s;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, evt_state, d;
  mps_rx_s rx_in;
  logic col_o, col_oe, crs_o, crs_oe, rxd_oe, rx_dv_o, rx_dv_oe;
  logic rx_er_o, rx_er_oe, rx_clk_o, rx_clk_oe, mdio_o, mdio_oe, irq;
  logic irq_pin_o, irq_pin_oe, drive_strength_strap, ten_meg_serial_select;
  logic [3:0] rxd_o;
  logic [15:0] reg_rdata;
  int n_fail = 0;
  int n_tests = 0;
  int n;
  // Shared pins: device drive wins, else the strap level; MDIO pulled up
  wire col_i = col_oe ? col_o : col_s;
  wire crs_i = crs_oe ? crs_o : crs_s;
  wire [3:0] rxd_i = rxd_oe ? rxd_o : rxd_s;
  wire rx_dv_i = rx_dv_oe ? rx_dv_o : dv_s;
  wire rx_er_i = rx_er_oe ? rx_er_o : er_s;
  wire mdio_i = mdio_oe ? mdio_o : (mac_en ? mac_val : 1'b1);
  // Collision/carrier table: speed fdx col sqe rxa txa, then col crs
  localparam logic [7:0] TAB [7] = '{8'b101000_10, 8'b111000_00,
    8'b000100_10, 8'b100100_00, 8'b100001_01, 8'b110001_00, 8'b110010_01};

  mps_status_pins u_mps_status_pins (.clk, .rst_n, .speed_100,
    .full_duplex, .collision, .sqe, .rx_active, .tx_active, .rx_in,
    .evt_state, .repeater_i, .serial_i, .rx_en_i, .col_i, .col_o, .col_oe,
    .crs_i, .crs_o, .crs_oe, .rxd_i, .rxd_o, .rxd_oe, .rx_dv_i, .rx_dv_o,
    .rx_dv_oe, .rx_er_i, .rx_er_o, .rx_er_oe, .rx_clk_o, .rx_clk_oe, .mdc,
    .mdio_i, .mdio_o, .mdio_oe, .irq_pin_o, .irq_pin_oe, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .drive_strength_strap,
    .ten_meg_serial_select);
  mps_mac_model u_mps_mac_model (.mdc(mdc), .mdio_val(mac_val),
    .mdio_en(mac_en), .mdio_line(mdio_i));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Pins hold their strap levels for the whole reset
  task automatic do_reset();
    rst_n <= 1'b0;
    cyc(5);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // Receive clock period in system cycles, rise to rise
  task automatic rx_period(output int p);
    int k;
    k = 0;
    p = 0;
    while (rx_clk_o !== 1'b0 && k < 400) begin cyc(1); k++; end
    while (rx_clk_o !== 1'b1 && k < 800) begin cyc(1); k++; end
    do begin cyc(1); p++; end while (rx_clk_o !== 1'b0 && p < 400);
    do begin cyc(1); p++; end while (rx_clk_o !== 1'b1 && p < 800);
  endtask

  initial begin
    {rst_n, speed_100, full_duplex, collision, sqe, rx_active} = '0;
    {tx_active, repeater_i, serial_i, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata, evt_state, rx_in} = '0;
    rx_en_i = 1'b1;
    {col_s, crs_s, rxd_s, dv_s, er_s} = 8'b1_0_1010_1_1;
    do_reset();
    rd(ADDR_SELF, d);
    `CHK("self", 16'h003b, d)
    `CHK("straps", 2'b10, {drive_strength_strap, ten_meg_serial_select})
    `CHK("oe", 6'h3f, {col_oe, crs_oe, rxd_oe, rx_dv_oe, rx_er_oe, rx_clk_oe})
    rx_en_i <= 1'b0;
    cyc(5);
    `CHK("oe off", 5'h01, {rxd_oe, rx_dv_oe, rx_er_oe, rx_clk_oe, col_oe})
    rx_en_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      {speed_100, full_duplex, collision, sqe, rx_active, tx_active} <=
        TAB[i][7:2];
      cyc(3);
      `CHK("col crs", TAB[i][1:0], {col_o, crs_o})
    end
    rx_in <= 6'h25;
    cyc(3);
    `CHK("rx", 6'h25, {rx_dv_o, rx_er_o, rxd_o})
    rx_in <= 6'h00;
    cyc(3);
    `CHK("rx idle", 6'h00, {rx_dv_o, rx_er_o, rxd_o})
    speed_100 <= 1'b1;
    rx_period(n);
    `CHK("rxclk 100", int'(CLK_HZ / RXCLK_100_HZ), n)
    speed_100 <= 1'b0;
    rx_period(n);
    `CHK("rxclk nib", int'(CLK_HZ / RXCLK_NIB_HZ), n)
    // Interrupts: only bit 0 unmasked; a masked change must stay quiet
    wr(ADDR_MASK, 16'h0001);
    evt_state <= 16'h0002;
    cyc(3);
    `CHK("irq masked", 2'b00, {irq, irq_pin_oe})
    evt_state <= 16'h0003;
    cyc(3);
    `CHK("irq", 3'b110, {irq, irq_pin_oe, irq_pin_o})
    rd(ADDR_ISR, d);
    `CHK("isr", 16'h0003, d)
    cyc(1);
    `CHK("irq clr", 2'b00, {irq, irq_pin_oe})
    rd(ADDR_ISR, d);
    `CHK("isr clr", 16'h0000, d)
    evt_state <= 16'h0002;
    cyc(3);
    wr(ADDR_ISR, 16'h0001);
    cyc(2);
    `CHK("w1c", 2'b00, {irq, irq_pin_oe})
    wr(5'h05, 16'hffff);
    rd(5'h05, d);
    `CHK("unmapped", 16'h0000, d)
    // Management frames with an unrelated clock
    u_mps_mac_model.frame(OP_RD, 5'h1b, ADDR_SELF, 16'h0000, d);
    `CHK("mdio rd", 16'h003b, d)
    u_mps_mac_model.frame(OP_RD, 5'h02, ADDR_SELF, 16'h0000, d);
    `CHK("mdio other", 16'hffff, d)
    u_mps_mac_model.frame(OP_WR, 5'h1b, ADDR_MASK, 16'h00f0, d);
    cyc(10);
    rd(ADDR_MASK, d);
    `CHK("mdio wr", 16'h00f0, d)
    // Second reset: hub and serial straps, other address
    {repeater_i, serial_i} <= 2'b11;
    {col_s, crs_s, rxd_s, dv_s, er_s} <= 8'b0_1_0000_0_0;
    do_reset();
    rd(ADDR_SELF, d);
    `CHK("self 2", 16'h0004, d)
    rd(ADDR_MASK, d);
    `CHK("mask rst", MASK_RST, d)
    `CHK("serial", 1'b1, ten_meg_serial_select)
    rx_period(n);
    `CHK("rxclk ser", int'(CLK_HZ / RXCLK_SER_HZ), n)
    {full_duplex, rx_active, tx_active} <= 3'b001;
    cyc(3);
    `CHK("crs hub", 1'b0, crs_o)
    test_done();
  end

  // Whole run is roughly 26 us; a hang is cut off well after that
  initial begin
    #200us;
    n_fail++;
    test_done();
  end
endmodule
